// ==== shared/nvm_prog_pkg.sv ====
// constants for the nonvolatile programming control block
// assumes an APB slave with 32-bit data, one register per aligned word
package nvm_prog_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0]  EEPROM_CTRL_IDX  = 8'h1c;
    localparam logic [7:0]  OTP_CTRL_IDX     = 8'h1d;
    localparam logic [11:0] EEPROM_CTRL_ADDR = 12'h0070;
    localparam logic [11:0] OTP_CTRL_ADDR    = 12'h0074;
    // otp control fields
    localparam int OTP_LATCH_BIT = 2;
    localparam int OTP_POWER_BIT = 0;
    // eeprom control fields
    localparam int CHARGE_PUMP_BIT = 6;
    localparam int ERASE_HI_BIT    = 4;
    localparam int ERASE_LO_BIT    = 3;
    localparam int EE_LATCH_BIT    = 2;
    localparam int EE_RC_BIT       = 1;
    localparam int EE_POWER_BIT    = 0;
    localparam logic [7:0] OTP_CTRL_MASK    = 8'h05;
    localparam logic [7:0] EEPROM_CTRL_MASK = 8'h5f;
    localparam logic [7:0] CTRL_RESET       = 8'h00;
    // array geometry
    localparam logic [15:0] EEPROM_BASE     = 16'h0100;
    localparam logic [15:0] EEPROM_LAST     = 16'h019f;
    localparam int          EEPROM_BYTES    = 160;
    localparam int          EEPROM_BLOCK    = 32;
    localparam int          OTP_GROUP       = 4;
    localparam logic [7:0]  OTP_ERASED      = 8'h00;
    localparam logic [7:0]  EEPROM_ERASED   = 8'hff;
    // erase selections
    typedef enum logic [1:0] {
        ERASE_NONE  = 2'b00,
        ERASE_BYTE  = 2'b01,
        ERASE_BLOCK = 2'b10,
        ERASE_BULK  = 2'b11
    } erase_mode_t;
endpackage : nvm_prog_pkg

// ==== design/nvm_program_control.sv ====
// programming control for the otp array and the on-chip eeprom array
// assumes APB from software, and a cpu memory port for array accesses,
// both synchronous to core_clk; the otp cells themselves sit outside
`timescale 1ns/1ps

// Functional notes
// - otp latch set: cpu writes to otp are captured into programming latches
// - otp reads return no valid data while otp latch is set
// - otp power bit connects programming power to the otp array
// - write setting otp latch and power together from latch clear leaves power clear
// - otp power sets only when otp latch is already one
// - clearing otp latch clears otp power in the same update
// - up to four bytes sharing address bits 15..2 latched, each own slot
// - unprogrammed otp reads zero; programming only sets bits
// - eeprom holds 160 bytes at 0x0100..0x019f, byte programmable
// - eeprom high voltage from internal charge pump only
// - erased eeprom reads one; programming only clears bits
// - erase select: none, byte, 32-byte block, whole array
// - bulk erase at any eeprom address erases all 160 bytes
// - eeprom latch set: buses for programming, array reads inhibited
// - eeprom power bit routes pump voltage so operation proceeds
module nvm_program_control #(
    parameter int EE_BYTES = nvm_prog_pkg::EEPROM_BYTES,
    parameter int OTP_N    = nvm_prog_pkg::OTP_GROUP
) (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        clkEn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // cpu memory port
    input  wire logic        memWrite,
    input  wire logic        memRead,
    input  wire logic        otpSelect,
    input  wire logic [15:0] memAddr,
    input  wire logic [7:0]  memWdata,
    input  wire logic [7:0]  otpCellData,
    output logic [7:0]       memRdata,
    output logic             memRdValid,
    // otp programming side
    output logic             otpProgramPower,
    output logic [13:0]      otpLatchRow,
    output logic [31:0]      otpLatchData,
    output logic [3:0]       otpLatchValid,
    // eeprom analog controls
    output logic             chargePumpOn,
    output logic             eepromRcClockSelect,
    output logic             eepromPumpToArray
);
    // release is synchronous so no flop leaves reset a cycle before its neighbour
    logic rstMeta;
    logic rstSync;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rstMeta <= 1'b0;
            rstSync <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSync <= rstMeta;
        end
    end
    wire logic rstN = rstSync;

    logic [7:0] otpCtrl;
    logic [7:0] eeCtrl;
    logic [7:0] eeMem [EE_BYTES];
    logic [15:0] eeLatchAddr;
    logic [7:0]  eeLatchData;
    logic        eeLatchHeld;
    logic        eeDone;

    wire logic apbAccess = psel && penable;
    wire logic apbWr     = apbAccess && pwrite;
    wire logic otpLatch  = otpCtrl[nvm_prog_pkg::OTP_LATCH_BIT];
    wire logic eeprom_latch_enable   = eeCtrl[nvm_prog_pkg::EE_LATCH_BIT];
    wire logic eePower   = eeCtrl[nvm_prog_pkg::EE_POWER_BIT];
    wire logic eePump    = eeCtrl[nvm_prog_pkg::CHARGE_PUMP_BIT];
    wire logic [1:0] eraseSel = {eeCtrl[nvm_prog_pkg::ERASE_HI_BIT],
                                 eeCtrl[nvm_prog_pkg::ERASE_LO_BIT]};
    wire logic inEeprom = (memAddr >= nvm_prog_pkg::EEPROM_BASE)
                       && (memAddr <= nvm_prog_pkg::EEPROM_LAST);
    wire logic [15:0] eeOffset = memAddr - nvm_prog_pkg::EEPROM_BASE;

    // otp control: interlock between latch and power
    logic [7:0] next_otpCtrl;
    always_comb begin
        logic wantLatch;
        logic wantPower;
        wantLatch = pwdata[nvm_prog_pkg::OTP_LATCH_BIT];
        wantPower = pwdata[nvm_prog_pkg::OTP_POWER_BIT];
        next_otpCtrl = nvm_prog_pkg::CTRL_RESET;
        next_otpCtrl[nvm_prog_pkg::OTP_LATCH_BIT] = wantLatch;
        // power only with latch already held and staying held
        next_otpCtrl[nvm_prog_pkg::OTP_POWER_BIT] =
            wantPower && otpLatch && wantLatch;
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            otpCtrl <= nvm_prog_pkg::CTRL_RESET;
        end else if (clkEn && apbWr && paddr == nvm_prog_pkg::OTP_CTRL_ADDR) begin
            otpCtrl <= next_otpCtrl;
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            eeCtrl <= nvm_prog_pkg::CTRL_RESET;
        end else if (clkEn && apbWr && paddr == nvm_prog_pkg::EEPROM_CTRL_ADDR) begin
            eeCtrl <= pwdata[7:0] & nvm_prog_pkg::EEPROM_CTRL_MASK;
        end
    end

    // register hit decode; anything else answers with an error
    wire logic apbSetup   = psel && !penable;
    wire logic otpCtrlHit = (paddr == nvm_prog_pkg::OTP_CTRL_ADDR);
    wire logic eeCtrlHit  = (paddr == nvm_prog_pkg::EEPROM_CTRL_ADDR);

    logic [31:0] next_prdata;
    logic        next_pslverr;
    always_comb begin
        next_prdata  = 32'h0000_0000;
        next_pslverr = 1'b0;
        if (apbSetup) begin
            if (otpCtrlHit) begin
                next_prdata = {24'h00_0000, otpCtrl};
            end else if (eeCtrlHit) begin
                next_prdata = {24'h00_0000, eeCtrl};
            end else begin
                next_pslverr = 1'b1;
            end
        end
    end

    // apb answer: zero wait states, frozen with the rest while clkEn is low
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (clkEn) begin
            pready  <= apbSetup;
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // otp programming latches: row captured by first write, four byte slots
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            otpLatchRow   <= 14'h0000;
            otpLatchData  <= 32'h0000_0000;
            otpLatchValid <= 4'h0;
        end else if (clkEn) begin
            if (!otpLatch) begin
                otpLatchValid <= 4'h0;
            end else if (memWrite && otpSelect) begin
                if (otpLatchValid == 4'h0) begin
                    otpLatchRow <= memAddr[15:2];
                end
                // bytes outside the captured row are dropped
                // slot picked by the low two address bits
                if (otpLatchValid == 4'h0 || memAddr[15:2] == otpLatchRow) begin
                    otpLatchData[memAddr[1:0]*8 +: 8] <= memWdata;
                    otpLatchValid[memAddr[1:0]]       <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            otpProgramPower <= 1'b0;
        end else if (clkEn) begin
            otpProgramPower <= otpCtrl[nvm_prog_pkg::OTP_POWER_BIT];
        end
    end

    // eeprom latch of one write while programming
    // held write stays until latch clears, so the address survives the pulse
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            eeLatchAddr <= 16'h0000;
            eeLatchData <= 8'h00;
            eeLatchHeld <= 1'b0;
        end else if (clkEn) begin
            if (!eeprom_latch_enable) begin
                eeLatchHeld <= 1'b0;
            end else if (memWrite && inEeprom && !eePower) begin
                eeLatchAddr <= eeOffset;
                eeLatchData <= memWdata;
                eeLatchHeld <= 1'b1;
            end
        end
    end

    // one operation per power pulse, applied when the pump drives the array
    // without this a long power pulse would apply the operation every cycle
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            eeDone <= 1'b0;
        end else if (clkEn) begin
            eeDone <= eePower && eeLatchHeld;
        end
    end

    wire logic eeGo = eePower && eePump && eeprom_latch_enable && eeLatchHeld && !eeDone;
    // block index taken once here rather than in every cell
    wire logic [15:0] eeBlockSel = eeLatchAddr / 16'(nvm_prog_pkg::EEPROM_BLOCK);

    // array storage; no reset so contents survive like nonvolatile cells
    for (genvar i = 0; i < EE_BYTES; i++) begin : g_cell
        localparam logic [15:0] IDX = 16'(i);
        localparam logic [15:0] BLK = IDX / 16'(nvm_prog_pkg::EEPROM_BLOCK);
        logic       sameByte;
        logic       sameBlock;
        logic       cellHit;
        logic       cellErase;
        logic [7:0] next_cell;
        // reach and new value decoded apart from the storage update
        always_comb begin
            sameByte  = (eeLatchAddr == IDX);
            sameBlock = (eeBlockSel == BLK);
            cellHit   = 1'b0;
            cellErase = 1'b1;
            case (nvm_prog_pkg::erase_mode_t'(eraseSel))
                nvm_prog_pkg::ERASE_NONE: begin
                    cellHit   = sameByte;
                    cellErase = 1'b0;
                end
                nvm_prog_pkg::ERASE_BYTE: begin
                    cellHit = sameByte;
                end
                nvm_prog_pkg::ERASE_BLOCK: begin
                    cellHit = sameBlock;
                end
                default: begin
                    cellHit = 1'b1;
                end
            endcase
            // programming can only pull bits low; erase returns them high
            if (cellErase) begin
                next_cell = nvm_prog_pkg::EEPROM_ERASED;
            end else begin
                next_cell = eeMem[i] & eeLatchData;
            end
        end

        always_ff @(posedge core_clk) begin
            if (clkEn && eeGo && cellHit) begin
                eeMem[i] <= next_cell;
            end
        end
    end

    // array read path
    logic [7:0] next_memRdata;
    logic       next_memRdValid;
    always_comb begin
        next_memRdata   = 8'h00;
        next_memRdValid = 1'b0;
        if (memRead && otpSelect && !otpLatch) begin
            // cells outside hold the erased value of zero
            next_memRdata   = otpCellData | nvm_prog_pkg::OTP_ERASED;
            next_memRdValid = 1'b1;
        end else if (memRead && inEeprom && !eeprom_latch_enable) begin
            next_memRdata   = eeMem[eeOffset[7:0]];
            next_memRdValid = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            memRdata   <= 8'h00;
            memRdValid <= 1'b0;
        end else if (clkEn) begin
            memRdata   <= next_memRdata;
            memRdValid <= next_memRdValid;
        end
    end

    // analog controls registered so they never glitch on a bus write
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            chargePumpOn        <= 1'b0;
            eepromRcClockSelect <= 1'b0;
            eepromPumpToArray   <= 1'b0;
        end else if (clkEn) begin
            chargePumpOn        <= eePump;
            eepromRcClockSelect <= eeCtrl[nvm_prog_pkg::EE_RC_BIT];
            eepromPumpToArray   <= eePower && eePump;
        end
    end
endmodule : nvm_program_control

// ==== verification/nvm_prog_chk.sv ====
// port checker for the programming control block
// assumes clkEn held high while software is active
`timescale 1ns/1ps
module nvm_prog_chk (
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        clkEn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        memRead,
    input wire logic        memRdValid,
    input wire logic        otpProgramPower
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    wire logic eeA  = paddr == nvm_prog_pkg::EEPROM_CTRL_ADDR;
    wire logic otA  = paddr == nvm_prog_pkg::OTP_CTRL_ADDR;
    wire logic otpW = psel && penable && pwrite && otA;
    apb_answer_a:
        assert property (psel && !penable && clkEn ##1 clkEn |-> pready) else $error("no answer");
    apb_phase_a:
        assert property (pready |-> psel && penable) else $error("answer outside access");
    rdata_idle_a:
        assert property (!pready |-> prdata == 32'h0000_0000) else $error("read data not idle");
    slverr_map_a:
        assert property (pready |-> pslverr == (!eeA && !otA)) else $error("bad error flag");
    otp_mask_a:
        assert property (pready && !pwrite && otA |-> (prdata & 32'hffff_fffa) == 32'h0000_0000)
            else $error("otp reserved bits set");
    ee_mask_a:
        assert property (pready && !pwrite && eeA |-> (prdata & 32'hffff_ffa0) == 32'h0000_0000)
            else $error("eeprom reserved bits set");
    power_rise_a:
        assert property ($rose(otpProgramPower) |-> $past(otpW && pwdata[2] && pwdata[0], 2))
            else $error("power set without latch");
    power_drop_a:
        assert property (otpW && !pwdata[2] |-> ##2 !otpProgramPower) else $error("power kept");
    rd_valid_a:
        assert property (memRdValid |-> $past(memRead)) else $error("stray read valid");
endmodule : nvm_prog_chk

bind nvm_program_control nvm_prog_chk u_chk (.core_clk, .resetn, .clkEn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .memRead, .memRdValid,
    .otpProgramPower);

// ==== verification/tb_nvm_program_control.sv ====
// self-checking bench for the programming control block
// drives apb and the cpu memory port itself; clkEn stays high
`timescale 1ns/1ps
module tb_nvm_program_control;
    localparam logic [11:0] EEC = nvm_prog_pkg::EEPROM_CTRL_ADDR;
    localparam logic [11:0] OTC = nvm_prog_pkg::OTP_CTRL_ADDR;
    logic        core_clk = 0, resetn = 0, clkEn = 1, psel = 0, penable = 0, pwrite = 0;
    logic        memWrite = 0, memRead = 0, otpSelect = 0, pready, pslverr, memRdValid;
    logic        otpProgramPower, chargePumpOn, eepromRcClockSelect, eepromPumpToArray;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, otpLatchData, r;
    logic [15:0] memAddr = 0;
    logic [7:0]  memWdata = 0, otpCellData = 8'h3c, memRdata;
    logic [13:0] otpLatchRow;
    logic [3:0]  otpLatchValid;
    logic        e;
    int          errTotal = 0, checkCount = 0;
    always #2.5 core_clk = ~core_clk;
    nvm_program_control DUT (.core_clk, .resetn, .clkEn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr, .memWrite, .memRead, .otpSelect, .memAddr,
        .memWdata, .otpCellData, .memRdata, .memRdValid, .otpProgramPower, .otpLatchRow,
        .otpLatchData, .otpLatchValid, .chargePumpOn, .eepromRcClockSelect, .eepromPumpToArray);
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            errTotal++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge core_clk);
        penable <= 1'b1;
        // wait bounded; a slave that never answers counts as a mismatch
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk("pready", 32'(pready), 32'h1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic rd(input string n, input logic [11:0] a, input logic [31:0] x, input logic f);
        apb(1'b0, a, 32'h0000_0000);
        chk(n, r, x);
        chk({n, "_err"}, 32'(e), 32'(f));
    endtask : rd
    task automatic mem(input logic w, input logic s, input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        {memWrite, memRead, otpSelect, memAddr, memWdata} <= {w, !w, s, a, d};
        @(posedge core_clk);
        {memWrite, memRead} <= 2'b00;
        #1;
    endtask : mem
    task automatic mr(input string n, input logic s, input logic [15:0] a, input logic v,
                      input logic [7:0] x);
        mem(1'b0, s, a, 8'h00);
        chk(n, 32'(memRdValid), 32'(v));
        if (v) chk(n, 32'(memRdata), 32'(x));
    endtask : mr
    // pump on, latch, chosen erase mode; power pulsed once with the write held
    task automatic eeOp(input logic [1:0] m, input logic [15:0] a, input logic [7:0] d);
        apb(1'b1, EEC, {24'h0, 3'b010, m, 3'b100});
        mem(1'b1, 1'b0, a, d);
        apb(1'b1, EEC, {24'h0, 3'b010, m, 3'b101});
        apb(1'b1, EEC, {24'h0, 3'b010, m, 3'b100});
        apb(1'b1, EEC, 32'h0000_0000);
    endtask : eeOp
    task automatic reportAndStop;
        $display("checks %0d mismatches %0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : reportAndStop
    initial begin
        #20000;
        errTotal++;
        reportAndStop();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge core_clk);
        rd("ee_reset", EEC, 32'h0, 1'b0);
        rd("otp_reset", OTC, 32'h0, 1'b0);
        rd("unmapped", 12'h078, 32'h0, 1'b1);
        apb(1'b1, EEC, 32'hffff_ffff);
        rd("ee_mask", EEC, 32'h5f, 1'b0);
        chk("pump_outs", 32'({chargePumpOn, eepromRcClockSelect, eepromPumpToArray}), 32'h7);
        apb(1'b1, EEC, 32'h0000_0000);
        rd("ee_clear", EEC, 32'h0, 1'b0);
        chk("pump_off", 32'({chargePumpOn, eepromRcClockSelect, eepromPumpToArray}), 32'h0);
        $display("register test done");
        apb(1'b1, OTC, 32'h1);
        rd("power_alone", OTC, 32'h0, 1'b0);
        apb(1'b1, OTC, 32'h5);
        rd("both_at_once", OTC, 32'h4, 1'b0);
        apb(1'b1, OTC, 32'h5);
        rd("power_set", OTC, 32'h5, 1'b0);
        chk("power_pin", 32'(otpProgramPower), 32'h1);
        apb(1'b1, OTC, 32'h1);
        rd("latch_clear", OTC, 32'h0, 1'b0);
        chk("power_off", 32'(otpProgramPower), 32'h0);
        $display("interlock test done");
        apb(1'b1, OTC, 32'h4);
        for (int i = 0; i < 4; i++) mem(1'b1, 1'b1, 16'h0700 + 16'(i), 8'ha0 + 8'(i));
        mem(1'b1, 1'b1, 16'h0710, 8'h55);
        chk("latch_row", 32'(otpLatchRow), 32'h1c0);
        chk("latch_data", otpLatchData, 32'ha3a2_a1a0);
        chk("latch_valid", 32'(otpLatchValid), 32'hf);
        mr("otp_locked", 1'b1, 16'h0700, 1'b0, 8'h00);
        apb(1'b1, OTC, 32'h0);
        mr("otp_read", 1'b1, 16'h0700, 1'b1, 8'h3c);
        chk("latch_drop", 32'(otpLatchValid), 32'h0);
        $display("otp test done");
        eeOp(2'b11, 16'h0150, 8'h00);
        mr("bulk_lo", 1'b0, 16'h0100, 1'b1, 8'hff);
        mr("bulk_hi", 1'b0, 16'h019f, 1'b1, 8'hff);
        eeOp(2'b00, 16'h0100, 8'ha5);
        eeOp(2'b00, 16'h0100, 8'h0f);
        mr("prog_and", 1'b0, 16'h0100, 1'b1, 8'h05);
        eeOp(2'b00, 16'h011f, 8'h00);
        eeOp(2'b00, 16'h0120, 8'h00);
        eeOp(2'b10, 16'h0105, 8'h00);
        mr("blk_in", 1'b0, 16'h011f, 1'b1, 8'hff);
        mr("blk_out", 1'b0, 16'h0120, 1'b1, 8'h00);
        eeOp(2'b01, 16'h0120, 8'h00);
        mr("byte_erase", 1'b0, 16'h0120, 1'b1, 8'hff);
        apb(1'b1, EEC, 32'h44);
        mr("ee_locked", 1'b0, 16'h0100, 1'b0, 8'h00);
        $display("eeprom test done");
        reportAndStop();
    end
endmodule : tb_nvm_program_control
